// file: src/cgs_pkg.sv
// Purpose: Shared constants for the clock generator sync and status event block.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register, data in bits 7:0.
// Notes: Register byte address is four times the register index.
package cgs_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam logic [6:0] IDX_SYNC_CTRL = 7'd12;
    localparam logic [6:0] IDX_INT_LIVE = 7'd13;
    localparam logic [6:0] IDX_INT_CTRL = 7'd14;
    localparam logic [6:0] IDX_POLARITY = 7'd15;
    localparam logic [6:0] IDX_INT_LATCH = 7'd16;
    localparam logic [6:0] IDX_INT_CFG = 7'd17;
    localparam logic [6:0] IDX_INT_MASK = 7'd18;
    localparam logic [6:0] IDX_PIN_MUTE = 7'd23;
    localparam logic [6:0] IDX_LOS_CFG = 7'd25;
    localparam logic [6:0] IDX_SEL_ZERO = 7'd27;
    localparam logic [6:0] IDX_SEL_ONE = 7'd28;
    localparam logic [6:0] IDX_PLL1_CTRL = 7'd56;
    localparam logic [6:0] IDX_PLL2_CTRL = 7'd71;
    localparam int SYNC_BIT = 6;
    localparam int SYNC_EN_BIT = 1;
    localparam int INT_EN_BIT = 0;
    localparam int INT_AND_BIT = 1;
    localparam int INT_CTRL_LOW = 0;
    localparam int INT_FIELD_LSB = 2;
    localparam logic [2:0] INT_FIELD_ON = 3'h7;
    localparam logic [7:0] SYNC_CTRL_RST = 8'h40;
    localparam logic [7:0] ZERO_RST = 8'h00;
    localparam logic [3:0] SEL_PRI_LOS = 4'h0;
    localparam logic [3:0] SEL_SEC_LOS = 4'h1;
    localparam logic [3:0] SEL_PLL1_LOL = 4'h2;
    localparam logic [3:0] SEL_PLL1_REF = 4'h3;
    localparam logic [3:0] SEL_PLL1_FB = 4'h4;
    localparam logic [3:0] SEL_PLL2_LOL = 4'h5;
    localparam logic [3:0] SEL_PLL2_REF = 4'h6;
    localparam logic [3:0] SEL_PLL2_FB = 4'h7;
    localparam logic [3:0] SEL_PLL1_CAL = 4'h8;
    localparam logic [3:0] SEL_PLL2_CAL = 4'h9;
    localparam logic [3:0] SEL_INTERRUPT = 4'ha;
    localparam logic [3:0] SEL_PLL1_M = 4'hb;
    localparam logic [3:0] SEL_PLL2_M = 4'hc;
    localparam logic [3:0] SEL_EEPROM = 4'hd;
    localparam logic [3:0] SEL_PLL1_SW = 4'he;
    localparam logic [3:0] SEL_PLL2_SW = 4'hf;
    localparam logic [1:0] SYNC_SLOW_EDGES = 2'd2;
    localparam logic [1:0] SYNC_VCO_CYCLES = 2'd2;
    localparam logic [7:0] SLIP_LIMIT = 8'd4;
    typedef enum logic [1:0] {SYNC_IDLE, SYNC_EDGE_WAIT, SYNC_VCO_WAIT} cgs_sync_e;
endpackage : cgs_pkg

// file: src/cgs_sync_status.sv
// Purpose: Output sync sequencing, device vital monitoring, status pins and interrupt logic.
// Assumes: One clock stands in for the VCO-derived domain; pulse inputs are one clk wide.
// Notes: Divided-by-two clock codes toggle on tick pulses from the divider models outside.
`timescale 1ns/1ps
// Function
// RULE1 - One active-low request syncs all dividers.
// RULE2 - Request from pin in soft mode, or register.
// RULE3 - Per-PLL sync enable gates mute and reset.
// RULE4 - Level 0 tri-states and resets; 1 runs.
// RULE5 - Latency: slow-clock edges plus VCO cycles.
// RULE6 - Driver holds sync three slow edges minimum.
// RULE7 - Output gating changes only at clock-low moments.
// RULE8 - Two status pins carry selected vitals.
// RULE9 - Selection codes map to listed vitals.
// RULE10 - Divider clock codes output halved clocks.
// RULE11 - Programmable polarity on each status pin.
// RULE12 - Interrupt drives active-high on selecting pin.
// RULE13 - Software enables interrupt with three settings.
// RULE14 - Control bit picks AND or OR combine.
// RULE15 - Mask bits ignore chosen interrupt sources.
// RULE16 - Latched status readable when enabled, clears on read.
// RULE17 - Real-time status ignores enable, clears on read.
// RULE18 - Differential loss below two-bit swing threshold.
// RULE19 - Single-ended loss may use slew edges.
// RULE20 - Lock detector counts slips, flags, resets count.
// RULE21 - Status clock pin muted while PLL unlocked.
// RULE22 - Read-only bits ignore writes.
// RULE23 - Sync pin passes two-stage synchronizer.
module cgs_sync_status (
    input wire logic clk,
    input wire logic rst,
    input wire logic [cgs_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [cgs_pkg::DATA_W-1:0] writedata,
    output logic [cgs_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic sync_request_pin,
    input wire logic config_source_select,
    input wire logic slowClkFall,
    input wire logic [1:0] refSwing [2],
    input wire logic [1:0] refSingleEnded,
    input wire logic [1:0] slewRiseFail,
    input wire logic [1:0] slewFallFail,
    input wire logic [1:0] slipPulse,
    input wire logic [1:0] slipWindowEnd,
    input wire logic [1:0] calActive,
    input wire logic eepromActive,
    input wire logic [1:0] autoSwitchBack,
    input wire logic [1:0] refDivTick,
    input wire logic [1:0] fbDivTick,
    input wire logic [1:0] mDivTick,
    input wire logic [1:0] refDivBypass,
    input wire logic [1:0] mDivBypass,
    output logic [1:0] outputMute,
    output logic [1:0] dividerReset,
    output logic event_pin_zero,
    output logic event_pin_one
);
    import cgs_pkg::*;

    logic [7:0] syncCtrl, intCtrl, polarity, intCfg, intMask, pinMute, losCfg, selZero, selOne;
    logic [7:0] pll1Ctrl, pll2Ctrl, intLive, intLatch, vitals, next_rdata;
    logic ack, wrDone, rdDone, pinMeta, pinSync, syncLevel, combined_interrupt;
    logic [6:0] index;
    logic [1:0] signal_loss, lock_loss, syncEn, halfRef, halfFb, halfM;
    logic [7:0] slipCount [2];
    cgs_sync_e syncState;
    logic [1:0] waitCount;
    logic appliedLevel;

    // Bus answer comes one cycle after the request so read data always stand from a flop.
    assign index = address[8:2];
    assign waitrequest = (read || write) && !ack;
    assign wrDone = write && ack;
    assign rdDone = read && ack;

    always_ff @(posedge clk) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= (read || write) && !ack;
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        if (index == IDX_SYNC_CTRL) begin
            next_rdata = syncCtrl;
        end else if (index == IDX_INT_LIVE) begin
            next_rdata = intLive;
        end else if (index == IDX_INT_CTRL) begin
            next_rdata = intCtrl;
        end else if (index == IDX_POLARITY) begin
            next_rdata = polarity;
        end else if (index == IDX_INT_LATCH) begin
            next_rdata = intCfg[INT_EN_BIT] ? intLatch : 8'h00; // [RULE16]
        end else if (index == IDX_INT_CFG) begin
            next_rdata = intCfg;
        end else if (index == IDX_INT_MASK) begin
            next_rdata = intMask;
        end else if (index == IDX_PIN_MUTE) begin
            next_rdata = pinMute;
        end else if (index == IDX_LOS_CFG) begin
            next_rdata = losCfg;
        end else if (index == IDX_SEL_ZERO) begin
            next_rdata = selZero;
        end else if (index == IDX_SEL_ONE) begin
            next_rdata = selOne;
        end else if (index == IDX_PLL1_CTRL) begin
            next_rdata = pll1Ctrl;
        end else if (index == IDX_PLL2_CTRL) begin
            next_rdata = pll2Ctrl;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            readdata <= '0;
        end else if (read && !ack) begin
            readdata <= {24'h000000, next_rdata};
        end
    end

    // Status registers have no write path; unmapped writes are dropped. [RULE22]
    always_ff @(posedge clk) begin
        if (rst) begin
            syncCtrl <= SYNC_CTRL_RST;
            intCtrl <= ZERO_RST;
            polarity <= ZERO_RST;
            intCfg <= ZERO_RST;
            intMask <= ZERO_RST;
            pinMute <= ZERO_RST;
            losCfg <= ZERO_RST;
            selZero <= ZERO_RST;
            selOne <= ZERO_RST;
            pll1Ctrl <= ZERO_RST;
            pll2Ctrl <= ZERO_RST;
        end else if (wrDone) begin
            if (index == IDX_SYNC_CTRL) begin
                syncCtrl <= writedata[7:0];
            end else if (index == IDX_INT_CTRL) begin
                intCtrl <= writedata[7:0];
            end else if (index == IDX_POLARITY) begin
                polarity <= writedata[7:0];
            end else if (index == IDX_INT_CFG) begin
                intCfg <= writedata[7:0];
            end else if (index == IDX_INT_MASK) begin
                intMask <= writedata[7:0];
            end else if (index == IDX_PIN_MUTE) begin
                pinMute <= writedata[7:0];
            end else if (index == IDX_LOS_CFG) begin
                losCfg <= writedata[7:0];
            end else if (index == IDX_SEL_ZERO) begin
                selZero <= writedata[7:0];
            end else if (index == IDX_SEL_ONE) begin
                selOne <= writedata[7:0];
            end else if (index == IDX_PLL1_CTRL) begin
                pll1Ctrl <= writedata[7:0];
            end else if (index == IDX_PLL2_CTRL) begin
                pll2Ctrl <= writedata[7:0];
            end
        end
    end

    // The pin is asynchronous to clk; only the second stage is ever looked at. [RULE23]
    always_ff @(posedge clk) begin
        if (rst) begin
            pinMeta <= 1'b1;
            pinSync <= 1'b1;
        end else begin
            pinMeta <= sync_request_pin;
            pinSync <= pinMeta;
        end
    end

    // Either source pulls the shared request low; the pin counts only in soft pin mode. [RULE1] [RULE2]
    assign syncLevel = (config_source_select ? pinSync : 1'b1) & syncCtrl[SYNC_BIT];
    assign syncEn = {pll2Ctrl[SYNC_EN_BIT], pll1Ctrl[SYNC_EN_BIT]};

    // A change waits two slow-clock falling edges, then two clk cycles, so gating lands while
    // the slowest output is low and skew stays within one cycle. [RULE5] [RULE7]
    always_ff @(posedge clk) begin
        if (rst) begin
            syncState <= SYNC_IDLE;
            waitCount <= 2'd0;
            appliedLevel <= 1'b1;
        end else begin
            case (syncState)
                SYNC_IDLE: begin
                    if (syncLevel != appliedLevel) begin
                        syncState <= SYNC_EDGE_WAIT;
                        waitCount <= 2'd0;
                    end
                end
                SYNC_EDGE_WAIT: begin
                    if (slowClkFall) begin
                        if (waitCount == SYNC_SLOW_EDGES - 2'd1) begin
                            syncState <= SYNC_VCO_WAIT;
                            waitCount <= 2'd0;
                        end else begin
                            waitCount <= waitCount + 2'd1;
                        end
                    end
                end
                SYNC_VCO_WAIT: begin
                    if (waitCount == SYNC_VCO_CYCLES - 2'd1) begin
                        syncState <= SYNC_IDLE;
                        appliedLevel <= syncLevel;
                    end else begin
                        waitCount <= waitCount + 2'd1;
                    end
                end
                default: begin
                    syncState <= SYNC_IDLE;
                end
            endcase
        end
    end

    // Only PLLs with sync enabled are muted and reset while the applied level is 0. [RULE3] [RULE4]
    always_ff @(posedge clk) begin
        if (rst) begin
            outputMute <= 2'b00;
            dividerReset <= 2'b00;
        end else begin
            outputMute <= syncEn & {2{!appliedLevel}};
            dividerReset <= syncEn & {2{!appliedLevel}};
        end
    end

    // Loss of signal per reference: index 0 is primary, 1 is secondary. [RULE18] [RULE19]
    for (genvar r = 0; r < 2; r++) begin : g_los
        logic [1:0] thr, slewSel;
        logic slewLoss;
        assign thr = losCfg[2*r +: 2];
        assign slewSel = losCfg[4 + 2*r +: 2];
        assign slewLoss = (slewSel[0] && slewRiseFail[r]) || (slewSel[1] && slewFallFail[r]);
        assign signal_loss[r] = (refSwing[r] < thr) || (refSingleEnded[r] && slewLoss);
    end

    // Slips are counted per window; beyond the limit the PLL is unlocked and counting restarts. [RULE20]
    for (genvar p = 0; p < 2; p++) begin : g_lock
        always_ff @(posedge clk) begin
            if (rst) begin
                slipCount[p] <= 8'd0;
                lock_loss[p] <= 1'b0;
            end else if (slipCount[p] > SLIP_LIMIT) begin
                slipCount[p] <= 8'd0;
                lock_loss[p] <= 1'b1;
            end else if (slipWindowEnd[p]) begin
                slipCount[p] <= 8'd0;
                lock_loss[p] <= 1'b0;
            end else if (slipPulse[p] && slipCount[p] != 8'hff) begin
                slipCount[p] <= slipCount[p] + 8'd1;
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                halfRef[p] <= 1'b0;
                halfFb[p] <= 1'b0;
                halfM[p] <= 1'b0;
            end else begin
                halfRef[p] <= halfRef[p] ^ refDivTick[p]; // [RULE10]
                halfFb[p] <= halfFb[p] ^ fbDivTick[p];
                halfM[p] <= halfM[p] ^ mDivTick[p];
            end
        end
    end

    assign vitals = {autoSwitchBack, calActive, lock_loss, signal_loss};

    // AND mode treats masked sources as satisfied; OR mode ignores them. [RULE14] [RULE15]
    always_comb begin
        logic srcHit;
        srcHit = intCfg[INT_AND_BIT] ? &(vitals | intMask) : |(vitals & ~intMask);
        combined_interrupt = srcHit && intCfg[INT_EN_BIT] && intCtrl[INT_CTRL_LOW]
                             && (intCtrl[INT_FIELD_LSB +: 3] == INT_FIELD_ON); // [RULE13]
    end

    // A vital that is present when a read completes survives it: set wins over clear. [RULE16] [RULE17]
    always_ff @(posedge clk) begin
        if (rst) begin
            intLive <= 8'h00;
            intLatch <= 8'h00;
        end else begin
            intLive <= (rdDone && index == IDX_INT_LIVE ? 8'h00 : intLive) | vitals;
            intLatch <= (rdDone && index == IDX_INT_LATCH ? 8'h00 : intLatch)
                        | (intCfg[INT_EN_BIT] ? (vitals & ~intMask) : 8'h00);
        end
    end

    function automatic logic pick_vital(input logic [3:0] code);
        logic v;
        v = 1'b0;
        case (code)
            SEL_PRI_LOS: v = signal_loss[0]; // [RULE9]
            SEL_SEC_LOS: v = signal_loss[1];
            SEL_PLL1_LOL: v = lock_loss[0];
            SEL_PLL1_REF: v = halfRef[0] && !refDivBypass[0]; // [RULE10]
            SEL_PLL1_FB: v = halfFb[0];
            SEL_PLL2_LOL: v = lock_loss[1];
            SEL_PLL2_REF: v = halfRef[1] && !refDivBypass[1];
            SEL_PLL2_FB: v = halfFb[1];
            SEL_PLL1_CAL: v = calActive[0];
            SEL_PLL2_CAL: v = calActive[1];
            SEL_INTERRUPT: v = combined_interrupt; // [RULE12]
            SEL_PLL1_M: v = halfM[0] && !mDivBypass[0];
            SEL_PLL2_M: v = halfM[1] && !mDivBypass[1];
            SEL_EEPROM: v = eepromActive;
            SEL_PLL1_SW: v = autoSwitchBack[0];
            SEL_PLL2_SW: v = autoSwitchBack[1];
            default: v = 1'b0;
        endcase
        return v;
    endfunction : pick_vital

    function automatic logic clock_muted(input logic [3:0] code, input logic muteOn);
        logic pll2;
        pll2 = (code == SEL_PLL2_REF) || (code == SEL_PLL2_FB) || (code == SEL_PLL2_M);
        if (!muteOn) begin
            return 1'b0;
        end else if (code == SEL_PLL1_REF || code == SEL_PLL1_FB || code == SEL_PLL1_M) begin
            return lock_loss[0];
        end
        return pll2 && lock_loss[1];
    endfunction : clock_muted

    // Polarity is applied last; a muted clock pin holds the inactive polarity level. [RULE8] [RULE11] [RULE21]
    always_ff @(posedge clk) begin
        if (rst) begin
            event_pin_zero <= 1'b0;
            event_pin_one <= 1'b0;
        end else begin
            event_pin_zero <= polarity[0] ^ (pick_vital(selZero[3:0]) && !clock_muted(selZero[3:0], pinMute[0]));
            event_pin_one <= polarity[1] ^ (pick_vital(selOne[3:0]) && !clock_muted(selOne[3:0], pinMute[1]));
        end
    end

    sequence req_wait_s;
        (read || write) && !ack;
    endsequence

    sequence answer_s;
        ack && !waitrequest;
    endsequence

    bus_answer_a: assert property (@(posedge clk) disable iff (rst) req_wait_s |=> answer_s) // [RULE22]
        else $error("Bus request not answered on the second cycle.");

    sync_pin_a: assert property (@(posedge clk) disable iff (rst)
        config_source_select && syncCtrl[SYNC_BIT] && $changed(pinMeta) |=> pinSync == $past(pinMeta)) // [RULE23]
        else $error("Sync pin did not pass the second stage.");

    sync_hold_a: assert property (@(posedge clk) disable iff (rst)
        syncState == SYNC_EDGE_WAIT && !slowClkFall |=> $stable(appliedLevel)) // [RULE5]
        else $error("Sync level applied before slow clock edges.");

    vco_wait_a: assert property (@(posedge clk) disable iff (rst)
        syncState == SYNC_EDGE_WAIT ##1 syncState == SYNC_VCO_WAIT |-> ##[1:2] syncState == SYNC_IDLE) // [RULE5]
        else $error("VCO wait did not end in two cycles.");

    sync_mute_a: assert property (@(posedge clk) disable iff (rst)
        !appliedLevel && syncEn[0] |=> outputMute[0] && dividerReset[0]) // [RULE3] [RULE4]
        else $error("Enabled PLL not muted while sync is low.");

    sync_free_a: assert property (@(posedge clk) disable iff (rst)
        !syncEn[1] |=> !outputMute[1] && !dividerReset[1]) // [RULE3]
        else $error("PLL muted without its sync enable.");

    lock_flag_a: assert property (@(posedge clk) disable iff (rst)
        slipCount[0] > SLIP_LIMIT |=> lock_loss[0] && slipCount[0] == 8'd0) // [RULE20]
        else $error("Slip limit did not flag loss of lock.");

    int_gate_a: assert property (@(posedge clk) disable iff (rst)
        !intCfg[INT_EN_BIT] || intCtrl[INT_FIELD_LSB +: 3] != INT_FIELD_ON |-> !combined_interrupt) // [RULE13]
        else $error("Interrupt active without full enable.");

    live_clear_a: assert property (@(posedge clk) disable iff (rst)
        rdDone && index == IDX_INT_LIVE |=> intLive == $past(vitals)) // [RULE17]
        else $error("Real-time status not cleared by read.");

    latch_set_a: assert property (@(posedge clk) disable iff (rst)
        intCfg[INT_EN_BIT] && vitals[0] && !intMask[0] |=> intLatch[0]) // [RULE16] [RULE15]
        else $error("Latched status missed an unmasked vital.");

    pin_select_a: assert property (@(posedge clk) disable iff (rst)
        selZero[3:0] == SEL_EEPROM |=> event_pin_zero == ($past(eepromActive) ^ $past(polarity[0]))) // [RULE8] [RULE11]
        else $error("Status pin does not follow selected vital.");

endmodule : cgs_sync_status

// file: tb/cgs_far_side.sv
// Purpose: Far-side model of the slowest output clock and the party driving the sync pin.
// Assumes: The slowest output clock falls once every FALL_GAP clk cycles and runs free.
// Notes: A short sync request is stretched, so a release never cuts a divider reset short.
`timescale 1ns/1ps
module cgs_far_side #(
    parameter int FALL_GAP = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic syncAsk,
    output logic slowClkFall,
    output logic sync_request_pin
);
    int gap;
    int held;
    always_ff @(posedge clk) begin
        if (rst) begin
            gap <= 0;
            slowClkFall <= 1'b0;
        end else begin
            gap <= (gap == FALL_GAP - 1) ? 0 : gap + 1;
            slowClkFall <= (gap == FALL_GAP - 1);
        end
    end
    // Held low until three slow falls have passed.
    always_ff @(posedge clk) begin
        if (rst) begin
            held <= 0;
            sync_request_pin <= 1'b1;
        end else if (syncAsk || (!sync_request_pin && held < 3)) begin
            sync_request_pin <= 1'b0;
            held <= held + ((slowClkFall && held < 3) ? 1 : 0);
        end else begin
            sync_request_pin <= 1'b1;
            held <= 0;
        end
    end
endmodule : cgs_far_side

// file: tb/test_clock_gen_sync_and_status_events.sv
// Purpose: Self-checking bench for the sync and status event block.
// Assumes: One wait cycle per bus access; register reads are checked from a queue.
// Notes: Pin and mute checks are made directly, since those outputs carry no strobe.
`timescale 1ns/1ps
module test_clock_gen_sync_and_status_events;
    import cgs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [DATA_W-1:0] writedata = '0;
    logic [DATA_W-1:0] readdata;
    logic waitrequest, syncPin, slowFall, pin0, pin1, eeprom = 1'b0, syncAsk = 1'b0, cfgSoft = 1'b0, v;
    logic [1:0] swing [2] = '{2'd3, 2'd3};
    logic [1:0] slip = '0, winEnd = '0, cal = '0, autoSw = '0, divTick = '0, byp = '0, mute, divRst;
    logic [1:0] se = '0, slewR = '0, slewF = '0;
    logic [3:0] codes [7] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hd, 4'he, 4'hf};
    logic [6:0] regs [14] = '{7'd12, 7'd13, 7'd14, 7'd15, 7'd16, 7'd17, 7'd18, 7'd23, 7'd25, 7'd27,
        7'd28, 7'd56, 7'd71, 7'd100};
    logic [7:0] p;
    logic [7:0] expQ [$];
    int unsigned rnd;
    int fail_count = 0;
    int num_checks = 0;
    always #5 clk = ~clk;
    cgs_sync_status cgs_sync_status_inst (
        .clk(clk), .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .sync_request_pin(syncPin),
        .config_source_select(cfgSoft), .slowClkFall(slowFall), .refSwing(swing), .refSingleEnded(se),
        .slewRiseFail(slewR), .slewFallFail(slewF), .slipPulse(slip), .slipWindowEnd(winEnd),
        .calActive(cal), .eepromActive(eeprom), .autoSwitchBack(autoSw), .refDivTick(divTick),
        .fbDivTick(divTick), .mDivTick(divTick), .refDivBypass(byp), .mDivBypass(byp),
        .outputMute(mute), .dividerReset(divRst), .event_pin_zero(pin0), .event_pin_one(pin1)
    );
    cgs_far_side cgs_far_side_inst (
        .clk(clk), .rst(rst), .syncAsk(syncAsk), .slowClkFall(slowFall), .sync_request_pin(syncPin)
    );
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        num_checks++;
        if (seen !== want) begin
            fail_count++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic stop_test();
        if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // A read notes its expected byte; the watcher below compares it when the data is taken.
    task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address <= {idx, 2'b00};
        writedata <= {24'h0, d};
        write <= wr;
        read <= !wr;
        if (!wr) expQ.push_back(d);
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) fail_count++;
        write <= 1'b0;
        read <= 1'b0;
    endtask : bus
    task automatic wait_mute(input logic [1:0] want);
        int n;
        n = 0;
        while (mute !== want && n < 300) begin
            @(posedge clk);
            n++;
        end
        check({6'h0, mute}, {6'h0, want});
        check({6'h0, divRst}, {6'h0, want});
    endtask : wait_mute
    always @(posedge clk) begin
        if (read && waitrequest === 1'b0) begin
            if (expQ.size() == 0) fail_count++;
            else check(readdata[7:0], expQ.pop_front());
        end
    end
    initial begin
        #200us;
        fail_count++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h47b4));
        tick(10);
        rst <= 1'b0;
        foreach (regs[i]) bus(1'b0, regs[i], (regs[i] == IDX_SYNC_CTRL) ? SYNC_CTRL_RST : ZERO_RST);
        bus(1'b1, IDX_INT_LIVE, 8'hff);
        bus(1'b0, IDX_INT_LIVE, 8'h00);
        bus(1'b1, IDX_SEL_ZERO, {4'h0, SEL_PLL1_FB});
        bus(1'b1, IDX_SEL_ONE, {4'h0, SEL_PLL1_REF});
        byp <= 2'b01;
        divTick <= 2'b11;
        @(posedge clk);
        divTick <= 2'b00;
        tick(3);
        check({7'h0, pin0}, 8'h01);
        check({7'h0, pin1}, 8'h00);
        bus(1'b1, IDX_PLL1_CTRL, 8'h02);
        bus(1'b1, IDX_SYNC_CTRL, 8'h00);
        wait_mute(2'b01);
        bus(1'b1, IDX_SYNC_CTRL, 8'h40);
        wait_mute(2'b00);
        bus(1'b1, IDX_PLL2_CTRL, 8'h02);
        syncAsk <= 1'b1;
        tick(80);
        check({6'h0, mute}, 8'h00);
        cfgSoft <= 1'b1;
        wait_mute(2'b11);
        syncAsk <= 1'b0;
        wait_mute(2'b00);
        bus(1'b1, IDX_INT_CTRL, 8'h01);
        bus(1'b1, IDX_INT_CFG, 8'h01);
        bus(1'b1, IDX_INT_MASK, 8'hfc);
        bus(1'b1, IDX_SEL_ZERO, {4'h0, SEL_INTERRUPT});
        bus(1'b1, IDX_LOS_CFG, 8'h0f);
        swing[0] <= 2'd0;
        tick(3);
        check({7'h0, pin0}, 8'h00);
        bus(1'b1, IDX_INT_CTRL, 8'h1d);
        tick(3);
        check({7'h0, pin0}, 8'h01);
        bus(1'b1, IDX_INT_CFG, 8'h03);
        tick(3);
        check({7'h0, pin0}, 8'h00);
        bus(1'b1, IDX_INT_CFG, 8'h01);
        bus(1'b1, IDX_INT_MASK, 8'hff);
        tick(3);
        check({7'h0, pin0}, 8'h00);
        bus(1'b1, IDX_INT_MASK, 8'hfe);
        tick(3);
        check({7'h0, pin0}, 8'h01);
        bus(1'b0, IDX_INT_LIVE, 8'h01);
        bus(1'b0, IDX_INT_LATCH, 8'h01);
        swing[0] <= 2'd3;
        tick(3);
        bus(1'b0, IDX_INT_LIVE, 8'h01);
        bus(1'b0, IDX_INT_LATCH, 8'h01);
        bus(1'b0, IDX_INT_LIVE, 8'h00);
        bus(1'b0, IDX_INT_LATCH, 8'h00);
        bus(1'b1, IDX_INT_CFG, 8'h00);
        swing[0] <= 2'd0;
        tick(3);
        bus(1'b0, IDX_INT_LATCH, 8'h00);
        bus(1'b0, IDX_INT_LIVE, 8'h01);
        swing[0] <= 2'd3;
        bus(1'b1, IDX_SEL_ZERO, {4'h0, SEL_PLL1_LOL});
        winEnd <= 2'b01;
        @(posedge clk);
        winEnd <= 2'b00;
        for (int k = 0; k < 5; k++) begin
            tick(2);
            check({7'h0, pin0}, 8'h00);
            slip <= 2'b01;
            @(posedge clk);
            slip <= 2'b00;
        end
        tick(3);
        check({7'h0, pin0}, 8'h01);
        // The divided feedback clock of PLL1 stands high here, so an unmuted pin would read 1.
        bus(1'b1, IDX_SEL_ZERO, {4'h0, SEL_PLL1_FB});
        bus(1'b1, IDX_PIN_MUTE, 8'h01);
        tick(3);
        check({7'h0, pin0}, 8'h00);
        foreach (codes[i]) begin
            rnd = $urandom();
            p = rnd[7:0];
            v = rnd[8];
            bus(1'b1, IDX_POLARITY, {6'h0, p[1:0]});
            bus(1'b1, IDX_SEL_ZERO, {4'h0, codes[i]});
            bus(1'b1, IDX_SEL_ONE, {4'h0, codes[i]});
            case (codes[i])
                4'h0: swing[0] <= v ? 2'd0 : 2'd3;
                4'h1: swing[1] <= v ? 2'd0 : 2'd3;
                4'h8: cal[0] <= v;
                4'h9: cal[1] <= v;
                4'hd: eeprom <= v;
                4'he: autoSw[0] <= v;
                default: autoSw[1] <= v;
            endcase
            tick(3);
            check({7'h0, pin0}, {7'h0, p[0] ^ v});
            check({7'h0, pin1}, {7'h0, p[1] ^ v});
            swing <= '{2'd3, 2'd3};
            cal <= 2'b00;
            eeprom <= 1'b0;
            autoSw <= 2'b00;
        end
        bus(1'b1, IDX_POLARITY, 8'h00);
        bus(1'b1, IDX_LOS_CFG, 8'h10);
        bus(1'b1, IDX_SEL_ZERO, {4'h0, SEL_PRI_LOS});
        se <= 2'b01;
        slewF <= 2'b01;
        tick(3);
        check({7'h0, pin0}, 8'h00);
        slewR <= 2'b01;
        tick(3);
        check({7'h0, pin0}, 8'h01);
        tick(4);
        stop_test();
    end
endmodule : test_clock_gen_sync_and_status_events
